/* File: verilog/pcs_pkg.sv */
package pcs_pkg;
    // data widths and fixed point: values carry four decimals
    localparam int DW = 32;
    localparam int TW = 21;
    localparam int HW = 20;
    localparam longint FIX_ONE = 64'd10000;
    localparam longint HYST_FULL = 64'd1000000;
    localparam longint REL_FULL = 64'd1000000;
    // clock and time base
    localparam longint CLK_HZ = 64'd100000000;
    localparam longint TICK_NS = 64'd1000000;
    localparam int TICK_CYC = int'(CLK_HZ * TICK_NS / 64'd1000000000);
    localparam int WIN_MS = 20;
    localparam int BLK_LEAD_MS = 5;
    // reset values of the settings, times in ms
    localparam logic [TW-1:0] OP_DELAY_DEF = 21'h000028;
    localparam logic [TW-1:0] REL_DELAY_DEF = 21'h00003c;
    localparam logic [TW-1:0] TIME_STEP_MS = 21'h000005;
    localparam logic [HW-1:0] HYST_DEF = 20'h07530;
    localparam logic [HW-1:0] HYST_MAX = 20'h7a120;
    localparam logic signed [DW-1:0] THR_DEF = 32'sh00000064;
    localparam logic signed [DW-1:0] MULT_ONE = 32'sh00002710;

    typedef enum logic [2:0] {
        PCS_OVER = 3'b000,
        PCS_OVER_ABS = 3'b001,
        PCS_UNDER = 3'b010,
        PCS_UNDER_ABS = 3'b011,
        PCS_DREL_SIGNED = 3'b100,
        PCS_DREL_ABS = 3'b101,
        PCS_DVAL_SIGNED = 3'b110,
        PCS_DVAL_ABS = 3'b111
    } pcs_mode_e;

    typedef enum logic [1:0] {
        PCS_NORMAL = 2'b00,
        PCS_START = 2'b01,
        PCS_TRIP = 2'b10,
        PCS_BLOCKED = 2'b11
    } pcs_cond_e;

    typedef struct packed {
        pcs_mode_e mode;
        logic signed [DW-1:0] threshold;
        logic [HW-1:0] hyst;
        logic signed [DW-1:0] block_limit;
        logic signed [DW-1:0] mult;
    } pcs_cmp_cfg_s;

    typedef struct packed {
        logic [1:0] count;
        logic [TW-1:0] op_delay;
        logic [TW-1:0] rel_delay;
        logic signed [DW-1:0] calc_threshold;
    } pcs_stage_cfg_s;

    typedef struct packed {
        pcs_cond_e cond;
        logic [16:0] tick_cnt;
        logic [4:0] win_cnt;
        logic [TW-1:0] op_rem;
        logic [TW-1:0] rel_cnt;
        logic blk;
        logic pickup;
        logic [2:0] hit;
        logic [2:0][DW-1:0] ref_val;
        logic [2:0][DW-1:0] scaled;
        logic [2:0][DW-1:0] ratio;
        logic [DW-1:0] calc_ratio;
    } pcs_state_s;
endpackage

/* File: verilog/pcs_prog_stage.sv */
`timescale 1ns/10ps
// What this block does
// - watches one, two or three selected magnitudes
// - signed multiplier scales input, product readable
// - ratio to threshold for each and calculated
// - per-threshold hysteresis percent, default three percent
// - condition normal, start, trip or blocked
// - time remaining to trip counts down
// - expected operating time is readable
// - operating delay up to 1800 s, default 40 ms
// - release delay, default 60 ms, on pick-up loss
// - eight comparator modes per magnitude, default over
// - over: signed value above threshold
// - absolute over: magnitude above threshold
// - under: below threshold, suppressed under block limit
// - absolute under: magnitude below, same suppression
// - signed relative change beyond percent in 20 ms
// - relative change beyond percent, either direction
// - signed change beyond value in 20 ms
// - change beyond value in 20 ms, either direction
// - signed threshold, resolution 0.0001, default 0.01
// - block sampled with each valid measurement; clear pick-up starts
// - blocked at pick-up stops; start releases
module pcs_prog_stage
    import pcs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // measurement subsystem, one sample per program cycle
    input wire logic meas_valid,
    input wire logic [2:0][DW-1:0] meas_in,
    input wire logic [DW-1:0] calculated_magnitude,
    input wire logic block_in,
    // settings
    input wire pcs_cmp_cfg_s [2:0] cmp_cfg,
    input wire pcs_stage_cfg_s stage_cfg,
    // status
    output pcs_cond_e condition,
    output logic start_o,
    output logic trip_o,
    output logic blocked_o,
    output logic [TW-1:0] expected_op_time,
    output logic [TW-1:0] time_to_trip,
    output logic [2:0][DW-1:0] scaled_magnitude,
    output logic [2:0][DW-1:0] ratio_out,
    output logic [DW-1:0] calc_ratio_out
);
    pcs_state_s s_q, s_d;
    logic [TW-1:0] exp_q;

    function automatic logic [DW-1:0] pcs_ratio(
        input logic signed [DW-1:0] x,
        input logic signed [DW-1:0] thr
    );
        longint q;
        q = 64'sd0;
        if (thr != 0) begin
            q = (longint'(x) * FIX_ONE) / longint'(thr);
        end
        return q[DW-1:0];
    endfunction

    function automatic longint pcs_abs(input longint v);
        return (v < 0) ? -v : v;
    endfunction

    function automatic logic pcs_cmp(
        input pcs_cmp_cfg_s c,
        input logic signed [DW-1:0] xin,
        input logic signed [DW-1:0] rin,
        input logic was
    );
        longint x;
        longint thr;
        longint band;
        longint lev;
        longint d;
        longint mag;
        longint lhs;
        longint rhs;
        logic hit;
        x = longint'(xin);
        thr = longint'(c.threshold);
        band = pcs_abs(thr) * longint'({44'h0, c.hyst}) / HYST_FULL;
        d = x - longint'(rin);
        hit = 1'b0;
        lhs = 64'sd0;
        rhs = 64'sd0;
        case (c.mode)
            PCS_OVER: begin
                hit = x > (was ? thr - band : thr);
            end
            PCS_OVER_ABS: begin
                hit = pcs_abs(x) > (was ? thr - band : thr);
            end
            PCS_UNDER: begin
                hit = (x < (was ? thr + band : thr))
                    && !(x < longint'(c.block_limit));
            end
            PCS_UNDER_ABS: begin
                hit = (pcs_abs(x) < (was ? thr + band : thr))
                    && !(pcs_abs(x) < longint'(c.block_limit));
            end
            default: begin
                lev = pcs_abs(thr) - (was ? band : 64'sd0);
                if (c.mode == PCS_DREL_SIGNED
                        || c.mode == PCS_DVAL_SIGNED) begin
                    mag = (thr < 0) ? -d : d;
                end else begin
                    mag = pcs_abs(d);
                end
                if (c.mode == PCS_DREL_SIGNED || c.mode == PCS_DREL_ABS) begin
                    lhs = mag * REL_FULL;
                    rhs = lev * pcs_abs(longint'(rin));
                end else begin
                    lhs = mag;
                    rhs = lev;
                end
                hit = lhs > rhs;
            end
        endcase
        return hit;
    endfunction

    always_comb begin
        logic tick;
        logic all_hit;
        logic [1:0] n_en;
        longint prod;
        s_d = s_q;
        tick = 1'b0;
        all_hit = 1'b1;
        prod = 64'sd0;
        n_en = (stage_cfg.count == 2'h0) ? 2'h1 : stage_cfg.count;
        if (s_q.tick_cnt == 17'(TICK_CYCLES - 1)) begin
            s_d.tick_cnt = 17'h00000;
            tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 17'h00001;
        end
        // 20 ms reference for the change modes
        if (tick) begin
            if (s_q.win_cnt == 5'(WIN_MS - 1)) begin
                s_d.win_cnt = 5'h00;
                s_d.ref_val = s_q.scaled;
            end else begin
                s_d.win_cnt = s_q.win_cnt + 5'h01;
            end
        end
        if (meas_valid) begin
            s_d.blk = block_in;
            for (int i = 0; i < 3; i++) begin
                prod = longint'(signed'(meas_in[i]))
                    * longint'(cmp_cfg[i].mult) / FIX_ONE;
                s_d.scaled[i] = prod[DW-1:0];
                s_d.ratio[i] = pcs_ratio(prod[DW-1:0],
                    cmp_cfg[i].threshold);
                s_d.hit[i] = pcs_cmp(cmp_cfg[i], prod[DW-1:0],
                    s_q.ref_val[i], s_q.hit[i]);
                if (i < int'(n_en) && !s_d.hit[i]) begin
                    all_hit = 1'b0;
                end
            end
            s_d.calc_ratio = pcs_ratio(calculated_magnitude,
                stage_cfg.calc_threshold);
            s_d.pickup = all_hit;
        end
        case (s_q.cond)
            PCS_NORMAL: begin
                s_d.rel_cnt = '0;
                if (s_q.pickup) begin
                    s_d.op_rem = stage_cfg.op_delay;
                    s_d.cond = s_q.blk ? PCS_BLOCKED : PCS_START;
                end
            end
            PCS_START: begin
                if (s_q.pickup && !s_q.blk) begin
                    s_d.rel_cnt = '0;
                    if (s_q.op_rem == '0) begin
                        s_d.cond = PCS_TRIP;
                    end else if (tick) begin
                        s_d.op_rem = s_q.op_rem - 21'h000001;
                    end
                end else if (s_q.rel_cnt >= stage_cfg.rel_delay) begin
                    s_d.cond = (s_q.pickup && s_q.blk) ?
                        PCS_BLOCKED : PCS_NORMAL;
                end else if (tick) begin
                    s_d.rel_cnt = s_q.rel_cnt + 21'h000001;
                end
            end
            PCS_TRIP: begin
                s_d.op_rem = '0;
                if (s_q.pickup) begin
                    s_d.rel_cnt = '0;
                end else if (s_q.rel_cnt >= stage_cfg.rel_delay) begin
                    s_d.cond = PCS_NORMAL;
                end else if (tick) begin
                    s_d.rel_cnt = s_q.rel_cnt + 21'h000001;
                end
            end
            default: begin
                if (!s_q.pickup) begin
                    s_d.cond = PCS_NORMAL;
                end else if (!s_q.blk) begin
                    s_d.op_rem = stage_cfg.op_delay;
                    s_d.rel_cnt = '0;
                    s_d.cond = PCS_START;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            exp_q <= '0;
        end else begin
            s_q <= s_d;
            exp_q <= stage_cfg.op_delay;
        end
    end

    // outputs come straight from the state flops
    assign condition = s_q.cond;
    assign start_o = (s_q.cond == PCS_START);
    assign trip_o = (s_q.cond == PCS_TRIP);
    assign blocked_o = (s_q.cond == PCS_BLOCKED);
    assign expected_op_time = exp_q;
    assign time_to_trip = (s_q.cond == PCS_START) ? s_q.op_rem : '0;
    assign scaled_magnitude = s_q.scaled;
    assign ratio_out = s_q.ratio;
    assign calc_ratio_out = s_q.calc_ratio;
endmodule

/* File: bench/pcs_prog_stage_checker.sv */
`timescale 1ns/10ps
module pcs_prog_stage_checker
    import pcs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // stimulus seen by the stage
    input wire logic meas_valid,
    input wire logic [2:0][DW-1:0] meas_in,
    input wire logic block_in,
    input wire pcs_cmp_cfg_s [2:0] cmp_cfg,
    input wire pcs_stage_cfg_s stage_cfg,
    // status
    input wire pcs_cond_e condition,
    input wire logic start_o,
    input wire logic trip_o,
    input wire logic blocked_o,
    input wire logic [TW-1:0] expected_op_time,
    input wire logic [TW-1:0] time_to_trip,
    input wire logic [2:0][DW-1:0] scaled_magnitude,
    input wire logic [2:0][DW-1:0] ratio_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_flag_decode: assert property (
        start_o == (condition == PCS_START) && trip_o == (condition == PCS_TRIP)
        && blocked_o == (condition == PCS_BLOCKED)) else $error("flag decode");
    a_scaled_value: assert property (meas_valid |=>
        longint'($signed(scaled_magnitude[0])) == longint'($signed($past(
        meas_in[0]))) * $past(cmp_cfg[0].mult) / 10000) else $error("scale");
    a_ratio_value: assert property (meas_valid && cmp_cfg[0].threshold != 0
        |=> longint'($signed(ratio_out[0])) == longint'($signed(
        scaled_magnitude[0])) * 10000 / cmp_cfg[0].threshold) else $error("ratio");
    a_exp_time: assert property (!$past(reset) |->
        expected_op_time == $past(stage_cfg.op_delay)) else $error("op time");
    a_remain_idle: assert property (!start_o |-> time_to_trip == 0)
        else $error("remain idle");
    a_remain_load: assert property ($rose(start_o) |->
        time_to_trip == stage_cfg.op_delay) else $error("remain load");
    a_remain_down: assert property (start_o && $past(start_o) |->
        $past(time_to_trip) - time_to_trip <= 1) else $error("remain step");
    a_trip_entry: assert property ($rose(trip_o) |->
        $past(start_o) && $past(time_to_trip) == 0) else $error("trip entry");
    a_start_cause: assert property ($rose(start_o) |->
        $past(meas_valid, 2) && !$past(block_in, 2)) else $error("start cause");
    a_block_cause: assert property ($rose(blocked_o) |->
        $past(meas_valid, 2) && $past(block_in, 2)) else $error("block cause");
endmodule

bind pcs_prog_stage pcs_prog_stage_checker u_pcs_prog_stage_checker (
    .sys_clk, .reset, .meas_valid, .meas_in, .block_in, .cmp_cfg, .stage_cfg,
    .condition, .start_o, .trip_o, .blocked_o, .expected_op_time,
    .time_to_trip, .scaled_magnitude, .ratio_out);

/* File: bench/pcs_meas_model.sv */
`timescale 1ns/10ps
module pcs_meas_model
    import pcs_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // values to present
    input wire logic [2:0][DW-1:0] level,
    // toward the stage
    output logic meas_valid = 1'b0,
    output logic [2:0][DW-1:0] meas_in = '0,
    output logic [DW-1:0] calculated_magnitude = '0
);
    // a sample every second cycle; junk on the bus in between
    always @(negedge sys_clk) begin
        meas_valid <= ~meas_valid;
        meas_in <= meas_valid ? ~level : level;
        calculated_magnitude <= meas_valid ? ~level[0] : level[0];
    end
endmodule

/* File: bench/pcs_prog_stage_tb.sv */
`timescale 1ns/10ps
module pcs_prog_stage_tb
    import pcs_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic block_in = 1'b0;
    logic [2:0][DW-1:0] level = '0;
    pcs_cmp_cfg_s [2:0] cmp_cfg;
    pcs_stage_cfg_s stage_cfg;
    logic meas_valid;
    logic [2:0][DW-1:0] meas_in, scaled, ratio;
    logic [DW-1:0] calc, calc_ratio;
    pcs_cond_e condition;
    logic start_o, trip_o, blocked_o;
    logic [TW-1:0] exp_time, ttt;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    pcs_meas_model u_pcs_meas_model (.sys_clk, .level, .meas_valid, .meas_in,
        .calculated_magnitude(calc));
    pcs_prog_stage #(.TICK_CYCLES(10)) u_pcs_prog_stage (.sys_clk, .reset,
        .meas_valid, .meas_in, .calculated_magnitude(calc), .block_in,
        .cmp_cfg, .stage_cfg, .condition, .start_o, .trip_o, .blocked_o,
        .expected_op_time(exp_time), .time_to_trip(ttt),
        .scaled_magnitude(scaled), .ratio_out(ratio),
        .calc_ratio_out(calc_ratio));
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge sys_clk);
        reset <= 1'b1;
        repeat (16) @(negedge sys_clk);
        reset <= 1'b0;
    endtask
    task automatic t_trip();
        int n;
        do_reset();
        level[0] <= 32'h00004e20;
        repeat (6) @(negedge sys_clk);
        chk(condition, PCS_START);
        chk(exp_time, OP_DELAY_DEF);
        chk(scaled[0], 32'h00004e20);
        chk(ratio[0], 32'h00004e20);
        chk(calc_ratio, 32'h00004e20);
        chk(ttt <= OP_DELAY_DEF && ttt >= 21'h000026, 1'b1);
        n = 6;
        while (trip_o !== 1'b1 && n < 700) begin
            @(negedge sys_clk);
            n++;
        end
        chk(n >= 392 && n <= 420, 1'b1);
        chk(ttt, '0);
        level[0] <= 32'h00002648;
        repeat (700) @(negedge sys_clk);
        chk(condition, PCS_TRIP);
        level[0] <= '0;
        n = 0;
        while (trip_o !== 1'b0 && n < 900) begin
            @(negedge sys_clk);
            n++;
        end
        chk(n >= 590 && n <= 615, 1'b1);
        chk(condition, PCS_NORMAL);
        $display("trip test done");
    endtask
    task automatic t_block();
        do_reset();
        stage_cfg.count <= 2'h2;
        level[0] <= 32'h00004e20;
        repeat (6) @(negedge sys_clk);
        chk(condition, PCS_NORMAL);
        level[1] <= 32'h00004e20;
        repeat (6) @(negedge sys_clk);
        chk(condition, PCS_START);
        do_reset();
        block_in <= 1'b1;
        repeat (6) @(negedge sys_clk);
        chk(condition, PCS_BLOCKED);
        block_in <= 1'b0;
        stage_cfg.count <= 2'h1;
        $display("block test done");
    endtask
    task automatic t_modes();
        pcs_mode_e md[12] = '{PCS_OVER, PCS_OVER, PCS_OVER_ABS, PCS_UNDER,
            PCS_UNDER, PCS_UNDER_ABS, PCS_DREL_SIGNED, PCS_DREL_SIGNED,
            PCS_DREL_ABS, PCS_DVAL_SIGNED, PCS_DVAL_SIGNED, PCS_DVAL_ABS};
        int v0[12] = '{0, 0, 0, 4, 4, 4, 4, 4, 4, 0, 4, 4};
        int v1[12] = '{4, -4, -4, 1, -1, -1, 6, 2, 2, 4, 0, 0};
        bit ex[12] = '{1, 0, 1, 1, 0, 1, 1, 0, 1, 1, 0, 1};
        stage_cfg.rel_delay <= '0;
        for (int i = 0; i < 12; i++) begin
            do_reset();
            cmp_cfg[0].mode <= md[i];
            level[1] <= '0;
            level[0] <= v0[i] * 5000;
            repeat (250) @(negedge sys_clk);
            chk(condition, PCS_NORMAL);
            level[0] <= v1[i] * 5000;
            repeat (6) @(negedge sys_clk);
            chk(start_o, ex[i]);
        end
        $display("mode test done");
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        for (int i = 0; i < 3; i++) begin
            cmp_cfg[i] = '{PCS_OVER, 32'sh2710, HYST_DEF, '0, MULT_ONE};
        end
        stage_cfg = '{2'h1, OP_DELAY_DEF, REL_DELAY_DEF, 32'sh2710};
        t_trip();
        t_block();
        t_modes();
        end_of_test();
    end
endmodule
